// >>> rtl/crcdma_top.sv
// CRC generator, channel byte pointers, AXI4-Lite register slave and input FIFO.
`timescale 1ns/1ps
module crcdma_fifo
   import crcdma_pkg::*;
#(
   parameter int W = 9,
   parameter int D = 32
) (
   // Clock, reset and enable.
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   // Filling side.
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Draining side.
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic [AW:0]   cnt_d;
   logic          full_q;
   logic          nfull_q;
   logic          empty_q;
   wire           push = ce && in_valid && !full_q;
   wire           pop  = ce && out_ready && !empty_q;

   assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   // Not-full has a flop of its own so that in_ready leaves the block straight from a register.
   assign in_ready  = nfull_q;
   assign out_valid = !empty_q;
   assign out_data  = mem[rp_q];

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_q    <= '0;
         rp_q    <= '0;
         cnt_q   <= '0;
         full_q  <= 1'b0;
         nfull_q <= 1'b1;
         empty_q <= 1'b1;
      end else if (ce) begin
         wp_q    <= wp_q + AW'(push);
         rp_q    <= rp_q + AW'(pop);
         cnt_q   <= cnt_d;
         full_q  <= (cnt_d == (AW+1)'(D));
         nfull_q <= (cnt_d != (AW+1)'(D));
         empty_q <= (cnt_d == '0);
      end
   end
endmodule

module crcdma_top
   import crcdma_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic           ce,
   // AXI4-Lite write channels.
   input  wire logic [AXW-1:0] s_awaddr,
   input  wire logic           s_awvalid,
   output logic                s_awready,
   input  wire logic [31:0]    s_wdata,
   input  wire logic [3:0]     s_wstrb,
   input  wire logic           s_wvalid,
   output logic                s_wready,
   output logic [1:0]          s_bresp,
   output logic                s_bvalid,
   input  wire logic           s_bready,
   // AXI4-Lite read channels.
   input  wire logic [AXW-1:0] s_araddr,
   input  wire logic           s_arvalid,
   output logic                s_arready,
   output logic [31:0]         s_rdata,
   output logic [1:0]          s_rresp,
   output logic                s_rvalid,
   input  wire logic           s_rready,
   // Channel byte stream.
   input  wire logic           in_valid,
   output logic                in_ready,
   input  crcdma_beat_t        in_beat,
   input  wire logic [NCH-1:0] chan_start,
   input  wire logic [NCH-1:0] chan_pattern
);
   function automatic logic [31:0] alias_apply(input logic [1:0] op, input logic [31:0] old,
                                               input logic [31:0] wd, input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wd;
      case (op)
         OP_CLR:  alias_apply = old & ~m;
         OP_SET:  alias_apply = old | m;
         OP_INV:  alias_apply = old ^ m;
         default: alias_apply = (old & ~{{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}}) | m;
      endcase
   endfunction

   function automatic logic [31:0] len_mask(input logic [4:0] pl);
      logic [32:0] one;
      one = 33'h1_0000_0001 & 33'h0_0000_0001;
      len_mask = 32'((one << (6'(pl) + 6'h1)) - 33'h1);
   endfunction

   // The whole byte is folded in one cycle, most significant bit first.
   function automatic logic [31:0] lfsr8(input logic [31:0] c, input logic [31:0] t,
                                         input logic [4:0] pl, input logic [7:0] b);
      logic [31:0] s;
      logic        fb;
      s = c;
      for (int k = 7; k >= 0; k--) begin
         fb = s[pl] ^ b[k];
         s  = ((s << 1) ^ (t & {32{fb}})) & len_mask(pl);
      end
      lfsr8 = s;
   endfunction

   function automatic logic [15:0] ip_add(input logic [15:0] c, input logic [7:0] b,
                                          input logic hi);
      logic [16:0] s;
      s = {1'b0, c} + {1'b0, (hi ? {b, 8'h00} : {8'h00, b})};
      ip_add = s[15:0] + {15'h0, s[16]};
   endfunction

   logic [31:0]    ctrl_q;
   logic [31:0]    crc_q;
   logic [31:0]    taps_q;
   logic           ip_hi_q;
   logic [15:0]    sptr_q [NCH];
   logic [15:0]    dptr_q [NCH];
   logic           awready_q;
   logic           wready_q;
   logic           bvalid_q;
   logic [1:0]     bresp_q;
   logic           aw_got_q;
   logic           w_got_q;
   logic [AXW-1:0] awaddr_q;
   logic [31:0]    wdata_q;
   logic [3:0]     wstrb_q;
   logic           arready_q;
   logic           rvalid_q;
   logic [31:0]    rdata_q;
   logic [1:0]     rresp_q;
   logic           f_valid;
   logic           f_ready;
   crcdma_beat_t   f_beat;
   logic           fifo_in_ready;

   // Register decode and views.
   wire            ip_mode   = ctrl_q[CTRL_TYPE_BIT];
   wire [4:0]      poly_len  = ctrl_q[CTRL_POLYNOMIAL_LENGTH_FIELD_LSB +: 5];
   wire            crc_en    = ctrl_q[CTRL_EN_BIT];
   wire [31:0]     lmask     = len_mask(poly_len);
   wire [31:0]     data_view = ip_mode ? {16'h0, ~crc_q[15:0]} : (crc_q & lmask);
   wire [1:0]      wr_op     = awaddr_q[3:2];
   wire            wr_ctrl   = (awaddr_q[AXW-1:4] == OFF_CTRL[AXW-1:4]);
   wire            wr_data   = (awaddr_q[AXW-1:4] == OFF_DATA[AXW-1:4]);
   wire            wr_taps   = (awaddr_q[AXW-1:4] == OFF_TAPS[AXW-1:4]);
   wire            wr_hit    = wr_ctrl || wr_data || wr_taps;
   wire            wr_do     = ce && aw_got_q && w_got_q && !bvalid_q;
   wire [31:0]     ctrl_new  = alias_apply(wr_op, ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
   wire [31:0]     taps_new  = alias_apply(wr_op, taps_q, wdata_q, wstrb_q);
   wire [31:0]     data_new  = alias_apply(wr_op, data_view, wdata_q, wstrb_q);
   wire [31:0]     seed      = ip_mode ? {16'h0, ~data_new[15:0]} : (data_new & lmask);
   wire            seed_wr   = wr_do && wr_data;

   // A seed write stalls the engine for that cycle so no byte is lost under it.
   assign f_ready = crc_en && !seed_wr;
   wire            step      = ce && f_valid && f_ready;
   wire [31:0]     crc_next  = ip_mode ? {16'h0, ip_add(crc_q[15:0], f_beat.data, ip_hi_q)}
                                       : lfsr8(crc_q, taps_q, poly_len, f_beat.data);

   wire            aw_fire   = ce && s_awvalid && awready_q;
   wire            w_fire    = ce && s_wvalid && wready_q;
   wire            ar_fire   = ce && s_arvalid && arready_q;
   wire [CHW-1:0]  rd_ch     = s_araddr[PTR_CH_LSB +: CHW];
   wire            rd_ptr    = (s_araddr[AXW-1:PTR_CH_LSB+CHW] == OFF_PTR[AXW-1:PTR_CH_LSB+CHW]);
   wire [15:0]     rd_pval   = s_araddr[PTR_DST_BIT] ? dptr_q[rd_ch] : sptr_q[rd_ch];
   wire            rd_crc    = (s_araddr[AXW-1:4] == OFF_CTRL[AXW-1:4]) ||
                               (s_araddr[AXW-1:4] == OFF_DATA[AXW-1:4]) ||
                               (s_araddr[AXW-1:4] == OFF_TAPS[AXW-1:4]);
   wire [31:0]     rd_val    = rd_ptr ? {16'h0, rd_pval} :
                               (s_araddr[AXW-1:4] == OFF_CTRL[AXW-1:4]) ? ctrl_q :
                               (s_araddr[AXW-1:4] == OFF_DATA[AXW-1:4]) ? data_view :
                               (s_araddr[AXW-1:4] == OFF_TAPS[AXW-1:4]) ? taps_q : 32'h0;
   wire            push      = ce && in_valid && fifo_in_ready;

   assign s_awready = awready_q;
   assign s_wready  = wready_q;
   assign s_bvalid  = bvalid_q;
   assign s_bresp   = bresp_q;
   assign s_arready = arready_q;
   assign s_rvalid  = rvalid_q;
   assign s_rdata   = rdata_q;
   assign s_rresp   = rresp_q;
   assign in_ready  = fifo_in_ready;

   crcdma_fifo #(
      .W         ($bits(crcdma_beat_t)),
      .D         (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .in_valid  (in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (in_beat),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_beat)
   );

   // Write address and data are taken in either order; the response follows both.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
      end else if (ce) begin
         if (aw_fire) begin
            awaddr_q  <= s_awaddr;
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
         end
         if (w_fire) begin
            wdata_q  <= s_wdata;
            wstrb_q  <= s_wstrb;
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && s_bready) begin
            bvalid_q  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
      end else if (ce) begin
         if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_val;
            rresp_q   <= (rd_ptr || rd_crc) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_q && s_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // A seed write to the data register wins over an engine step in the same cycle; control and taps writes let the step run.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q  <= CTRL_RESET;
         crc_q   <= VALUE_RESET;
         taps_q  <= TAPS_RESET;
         ip_hi_q <= 1'b1;
      end else if (ce) begin
         if (wr_do && wr_ctrl) begin
            ctrl_q <= ctrl_new;
         end
         if (wr_do && wr_taps) begin
            taps_q <= taps_new;
         end
         if (seed_wr) begin
            crc_q   <= seed;
            ip_hi_q <= 1'b1;
         end else if (step) begin
            crc_q   <= crc_next;
            ip_hi_q <= ip_mode ? !ip_hi_q : 1'b1;
         end
      end
   end

   // Clearing on a pattern hit or a start beats the count of the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < NCH; c++) begin
            sptr_q[c] <= PTR_RESET;
            dptr_q[c] <= PTR_RESET;
         end
      end else if (ce) begin
         for (int c = 0; c < NCH; c++) begin
            if (chan_start[c]) begin
               sptr_q[c] <= PTR_RESET;
               dptr_q[c] <= PTR_RESET;
            end else begin
               if (chan_pattern[c]) begin
                  sptr_q[c] <= PTR_RESET;
               end else if (push && in_beat.ch == CHW'(c)) begin
                  sptr_q[c] <= sptr_q[c] + 16'h1;
               end
               if (push && in_beat.ch == CHW'(c)) begin
                  dptr_q[c] <= dptr_q[c] + 16'h1;
               end
            end
         end
      end
   end

   sequence s_data_write;
      wr_do && wr_data && wr_op == OP_WRITE && wstrb_q == 4'hf;
   endsequence

   a_seed_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_data_write and (!ip_mode)) |=> crc_q == ($past(wdata_q) & lmask))
      else $error("seed write not loaded");
   a_read_current: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && s_araddr == OFF_DATA |=> s_rvalid && s_rdata == $past(data_view))
      else $error("crc value read wrong");
   a_lfsr_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && step && !ip_mode && !seed_wr |=> (crc_q & ~lmask) == 32'h0 || $past(ctrl_q) != ctrl_q)
      else $error("lfsr bits above length set");
   a_ip_upper: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_q && $past(ar_fire) && $past(s_araddr) == OFF_DATA && $past(ip_mode) |-> rdata_q[31:16] == 16'h0)
      else $error("ip mode upper half not zero");
   a_ip_compl: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_data_write and ip_mode) |=> data_view[15:0] == $past(wdata_q[15:0]))
      else $error("ip seed readback not complemented");
   a_ip_no_taps: assert property (@(posedge aclk) disable iff (!aresetn)
      step && ip_mode && !seed_wr |=> crc_q[15:0] == ip_add($past(crc_q[15:0]), $past(f_beat.data), $past(ip_hi_q)))
      else $error("ip checksum step wrong");
   a_lfsr_step: assert property (@(posedge aclk) disable iff (!aresetn)
      step && !ip_mode && !seed_wr |=> crc_q == lfsr8($past(crc_q), $past(taps_q), $past(poly_len), $past(f_beat.data)))
      else $error("lfsr step wrong");
   a_pattern_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && chan_pattern[0] |=> sptr_q[0] == 16'h0)
      else $error("pattern did not clear source pointer");
   a_ptr_count: assert property (@(posedge aclk) disable iff (!aresetn)
      push && in_beat.ch == '0 && !chan_start[0] |=> dptr_q[0] == $past(dptr_q[0]) + 16'h1)
      else $error("destination pointer did not count");
   a_ptr_upper: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && rd_ptr |=> s_rdata[31:16] == 16'h0 ##1 1'b1)
      else $error("pointer upper bits not zero");
   a_mode_select: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_do && wr_ctrl && wr_op == OP_WRITE && wstrb_q[1] |=> ip_mode == $past(wdata_q[CTRL_TYPE_BIT]))
      else $error("mode bit not applied");
   a_start_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && chan_start[1] |=> sptr_q[1] == 16'h0 && dptr_q[1] == 16'h0)
      else $error("start did not clear both pointers");
   a_ce_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      !ce |=> $stable(crc_q) && $stable(sptr_q[0]) && $stable(dptr_q[0]) && $stable(sptr_q[1]))
      else $error("state moved while disabled");
endmodule

// >>> rtl/crcdma_pkg.sv
// Constants and types shared by the CRC generator and its pointer registers.
package crcdma_pkg;
   localparam int          NCH            = 2;
   localparam int          CHW            = 1;
   localparam int          AXW            = 12;
   localparam int          FIFO_DEPTH     = 32;
   localparam logic [11:0] OFF_CTRL       = 12'h000;
   localparam logic [11:0] OFF_DATA       = 12'h010;
   localparam logic [11:0] OFF_TAPS       = 12'h020;
   localparam logic [11:0] OFF_PTR        = 12'h040;
   localparam int          PTR_DST_BIT    = 2;
   localparam int          PTR_CH_LSB     = 3;
   localparam logic [1:0]  OP_WRITE       = 2'h0;
   localparam logic [1:0]  OP_CLR         = 2'h1;
   localparam logic [1:0]  OP_SET         = 2'h2;
   localparam logic [1:0]  OP_INV         = 2'h3;
   localparam int          CTRL_TYPE_BIT  = 15;
   localparam int          CTRL_POLYNOMIAL_LENGTH_FIELD_LSB  = 8;
   localparam int          CTRL_EN_BIT    = 7;
   localparam int          CTRL_APP_BIT   = 6;
   localparam logic [31:0] CTRL_MASK      = 32'h0000_9fc0;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] VALUE_RESET    = 32'h0000_0000;
   localparam logic [31:0] TAPS_RESET     = 32'h0000_0000;
   localparam logic [15:0] PTR_RESET      = 16'h0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef struct packed {
      logic [CHW-1:0] ch;
      logic [7:0]     data;
   } crcdma_beat_t;
endpackage

// >>> bench/crcdma_src_model.sv
// Byte source standing in for the DMA channel data path that feeds the generator.
`timescale 1ns/1ps
module crcdma_src_model
   import crcdma_pkg::*;
(
   // Clock and reset.
   input  wire logic    aclk,
   input  wire logic    aresetn,
   // Pacing.
   input  wire logic    slow,
   // Byte stream toward the block.
   input  wire logic    in_ready,
   output logic         in_valid,
   output crcdma_beat_t in_beat
);
   crcdma_beat_t q[$];

   initial begin
      in_valid = 1'b0;
      in_beat  = '0;
   end

   // A byte is held until the edge that takes it; an idle bus inverts its data on every idle edge,
   // starting from the inverse of the last byte, so that a block reading stale data cannot pass by luck.
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_valid <= 1'b0;
      end else if (!in_valid || in_ready) begin
         if (q.size() > 0 && !(slow && $urandom_range(1, 0) == 1)) begin
            in_valid <= 1'b1;
            in_beat  <= q.pop_front();
         end else begin
            in_valid <= 1'b0;
            in_beat  <= ~in_beat;
         end
      end
   end
endmodule

// >>> bench/dma_crc_and_channel_pointers_tb.sv
// Self-checking bench for the CRC generator, its registers and the channel pointers.
`timescale 1ns/1ps
module dma_crc_and_channel_pointers_tb
   import crcdma_pkg::*;
;
   logic           aclk = 1'b0;
   logic           aresetn, slow;
   logic           ce = 1'b1;
   logic [AXW-1:0] s_awaddr, s_araddr;
   logic           s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic [31:0]    s_wdata, s_rdata;
   logic [3:0]     s_wstrb;
   logic           s_awready, s_wready, s_bvalid, s_arready, s_rvalid, in_valid, in_ready;
   logic [1:0]     s_bresp, s_rresp;
   crcdma_beat_t   in_beat;
   logic [NCH-1:0] chan_start, chan_pattern;
   int             n_fail = 0;
   int             tests_run = 0;
   int             cyc = 0;
   logic [33:0]    rq[$];
   logic [1:0]     bq[$];
   logic [31:0]    crc, taps, sh;
   logic [15:0]    s;
   logic [4:0]     pl;
   logic           ip, hi;
   logic [15:0]    cs[NCH];
   logic [15:0]    cd[NCH];

   always #2.5 aclk = ~aclk;

   crcdma_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
      .chan_start(chan_start), .chan_pattern(chan_pattern));

   crcdma_src_model src (.aclk(aclk), .aresetn(aresetn), .slow(slow), .in_ready(in_ready),
      .in_valid(in_valid), .in_beat(in_beat));

   task automatic test_done();
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Results are compared here as they appear, oldest note first.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         test_done();
      end
      if (aresetn && s_rvalid && s_rready) begin
         check("read data", {s_rresp, s_rdata}, rq.pop_front()); // Read value
      end
      if (aresetn && s_bvalid && s_bready) begin
         check("write response", {32'h0, s_bresp}, {32'h0, bq.pop_front()}); // Write response code
      end
   end

   task automatic wr(input logic [AXW-1:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      s_awaddr  <= a;
      s_awvalid <= 1'b1;
      s_wdata   <= d;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
   endtask

   task automatic rd(input logic [AXW-1:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, d});
      @(posedge aclk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      s_rready <= 1'b0;
   endtask

   function automatic logic [31:0] lmask(input logic [4:0] l);
      return (l == 5'd31) ? 32'hffffffff : (32'h1 << (l + 5'd1)) - 32'h1;
   endfunction

   // Bytes enter most significant bit first; a clear tap leaves its stage a plain shift.
   function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] b);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = c[pl] ^ b[i];
         c  = ((c << 1) ^ (taps & {32{fb}})) & lmask(pl);
      end
      return c;
   endfunction

   function automatic logic [31:0] vexp();
      return ip ? {16'h0, ~s} : crc;
   endfunction

   task automatic setmode(input logic m, input logic [4:0] l, input logic en);
      ip = m;
      pl = l;
      wr(OFF_CTRL, {16'h0, m, 2'b00, l, en, 1'b0, 6'h00}, RESP_OKAY); // Mode select
   endtask

   task automatic seed(input logic [31:0] v);
      wr(OFF_DATA, v, RESP_OKAY);
      crc = v & lmask(pl);
      s   = ~v[15:0];
      hi  = 1'b1;
   endtask

   // Both modes are tracked for every byte; the mode in force picks the expectation.
   task automatic feed(input int n);
      logic [7:0]  b;
      logic        ch;
      logic [16:0] t;
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         ch = 1'($urandom);
         src.q.push_back(crcdma_beat_t'({ch, b}));
         cs[ch]++;
         cd[ch]++;
         t = s + (hi ? {b, 8'h00} : {8'h00, b});
         s = t[15:0] + 16'(t[16]);
         hi = ~hi;
         crc = step(crc, b);
      end
   endtask

   // The engine drains one byte a cycle, so 40 cycles cover a full FIFO.
   task automatic settle();
      while (src.q.size() > 0 || in_valid) @(posedge aclk);
      repeat (40) @(posedge aclk);
   endtask

   task automatic ptrs();
      for (int c = 0; c < NCH; c++) begin
         rd(OFF_PTR + 12'(c * 8), {16'h0, cs[c]}, RESP_OKAY); // Source count
         rd(OFF_PTR + 12'(c * 8 + 4), {16'h0, cd[c]}, RESP_OKAY); // Destination count
      end
   endtask

   initial begin
      void'($urandom(59803));
      {aresetn, slow, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata, chan_start, chan_pattern} = '0;
      s_wstrb = 4'hf;
      for (int c = 0; c < NCH; c++) begin
         cs[c] = 16'h0;
         cd[c] = 16'h0;
      end
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFF_CTRL, 32'h0, RESP_OKAY); // Reset value
      rd(OFF_DATA, 32'h0, RESP_OKAY); // Reset value
      rd(OFF_TAPS, 32'h0, RESP_OKAY); // Reset value
      ptrs(); // Reset pointers
      taps = $urandom;
      wr(OFF_TAPS, taps, RESP_OKAY);
      rd(OFF_TAPS, taps, RESP_OKAY); // Taps readback
      for (int op = 1; op < 4; op++) begin
         sh = $urandom;
         wr(OFF_TAPS + 12'(op * 4), sh, RESP_OKAY);
         taps = (op == 1) ? (taps & ~sh) : (op == 2) ? (taps | sh) : (taps ^ sh);
         rd(OFF_TAPS, taps, RESP_OKAY); // Alias effect
      end
      wr(OFF_CTRL, 32'hffffffff, RESP_OKAY);
      rd(OFF_CTRL, CTRL_MASK, RESP_OKAY); // Control fields
      rd(12'h0f0, 32'h0, RESP_SLVERR); // Unmapped read
      wr(12'h0f0, 32'h1234, RESP_SLVERR); // Unmapped write
      wr(OFF_PTR, 32'hffffffff, RESP_SLVERR); // Pointer is read-only
      for (int k = 0; k < 4; k++) begin
         setmode(1'b0, 5'(k * 10 + (k == 3 ? 1 : 0)), 1'b1);
         taps = $urandom;
         wr(OFF_TAPS, taps, RESP_OKAY);
         seed($urandom);
         rd(OFF_DATA, vexp(), RESP_OKAY); // Seed masked to length
         slow <= k[0];
         feed(8 + k);
         settle();
         rd(OFF_DATA, vexp(), RESP_OKAY); // Shift result
      end
      ptrs(); // Counted bytes
      setmode(1'b1, 5'd7, 1'b1);
      taps = $urandom;
      wr(OFF_TAPS, taps, RESP_OKAY);
      seed($urandom);
      rd(OFF_DATA, vexp(), RESP_OKAY); // Complemented seed
      feed(7);
      settle();
      rd(OFF_DATA, vexp(), RESP_OKAY); // Checksum ignores taps
      {ce, chan_start} <= {1'b0, 2'b11};
      @(posedge aclk);
      {ce, chan_start} <= {1'b1, 2'b00};
      ptrs(); // Disabled block ignores start
      chan_pattern <= 2'b01;
      @(posedge aclk);
      chan_pattern <= 2'b00;
      cs[0] = 16'h0;
      ptrs(); // Pattern clears source only
      chan_start <= 2'b10;
      @(posedge aclk);
      chan_start <= 2'b00;
      cs[1] = 16'h0;
      cd[1] = 16'h0;
      ptrs(); // Start clears both
      setmode(1'b0, 5'd31, 1'b0);
      seed($urandom);
      slow <= 1'b0;
      feed(FIFO_DEPTH + 1);
      repeat (50) @(posedge aclk);
      check("fifo ready", {33'h0, in_ready}, 34'h0); // Full buffer refuses
      wr(OFF_CTRL + 12'h8, 32'h80, RESP_OKAY);
      settle();
      rd(OFF_DATA, vexp(), RESP_OKAY); // Drained bytes all folded into the CRC
      ptrs(); // Pointers after stall
      test_done();
   end
endmodule
